// ### hw/ttcpc_defs.vh
// constants for the at-speed transition-test capture pulse controller
// assumes a 32-bit classic wishbone register port and one 100 MHz core clock
`ifndef TTCPC_DEFS_VH
`define TTCPC_DEFS_VH

// clock and widths
`define TTCPC_CLK_PERIOD_NS   10
`define TTCPC_CNT_W           8
`define TTCPC_NUM_DOM         24
`define TTCPC_NUM_MEMLINK     4
`define TTCPC_ADR_W           8

// register byte addresses
`define TTCPC_ADR_CTRL        8'h00
`define TTCPC_ADR_COUNT       8'h04
`define TTCPC_ADR_TARGET      8'h08
`define TTCPC_ADR_STATUS      8'h0c

// control register fields
`define TTCPC_CTRL_DSEL       0
`define TTCPC_DSEL_CORE       1'h0
`define TTCPC_DSEL_IO         1'h1

// status register fields
`define TTCPC_ST_MODE         0
`define TTCPC_ST_ALIGN        1
`define TTCPC_ST_RUN          2
`define TTCPC_ST_DONE         3
`define TTCPC_ST_DSEL         4
`define TTCPC_ST_REM_LO       8
`define TTCPC_ST_REM_HI       15

// reset values
`define TTCPC_RST_COUNT       8'h00
`define TTCPC_RST_TARGET      24'h000000
`define TTCPC_ZERO_CNT        8'h00
`define TTCPC_ONE_CNT         8'h01

// domains 0..20 have a core clock header, 16..23 an io header
`define TTCPC_CORE_OK         24'h1fffff
`define TTCPC_IO_OK           24'hff0000

// controller states
`define TTCPC_S_IDLE          2'h0
`define TTCPC_S_ALIGN         2'h1
`define TTCPC_S_RUN           2'h2
`define TTCPC_S_DONE          2'h3

`endif

// ### hw/ttcpc_ctrl.v
// at-speed transition-test capture pulse controller with wishbone setup registers
// assumes all inputs synchronous to core_clk except the capture trigger pin,
// and io_sync_en as a one-cycle pulse marking each io clock edge (core/4)
//
// Overview of operation
// - capture trigger is synchronised, then its rise enables the pulse counter.
// - targeted core stops go low for exactly the programmed count, io stops for count/4 io cycles rounded down, pipelined out.
// - pulse counter is eight bits, up to 255 capture pulses per trigger.
// - one domain-select bit: zero core (default), one io.
// - several core domains, or several io domains, may pulse together.
// - array write-inhibit output is driven high throughout transition test.
// - counting starts aligned to an io sync-enable pulse in both domains.
// - target flops load ones for targets; stop outputs are their inverse.
// - target chain covers 24 domains, bit 0 nearest scan-in.
// - memory-link domain stops stay asserted during transition test.
// - misc-io and debug shared stop stays asserted, so untestable.
// - test protect output is test protect ORed with at-speed mode.
// - all control runs on core clock; io stops update on io sync pulses.
//
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ttcpc_defs.vh"

module ttcpc_ctrl #(
	parameter CNT_W   = `TTCPC_CNT_W,
	parameter NUM_DOM = `TTCPC_NUM_DOM,
	parameter NUM_ML  = `TTCPC_NUM_MEMLINK
) (
	input  wire                 core_clk,
	input  wire                 srst,
	// wishbone slave
	input  wire                 wb_cyc_i,
	input  wire                 wb_stb_i,
	input  wire                 wb_we_i,
	input  wire [7:0]           wb_adr_i,
	input  wire [3:0]           wb_sel_i,
	input  wire [31:0]          wb_dat_i,
	output reg  [31:0]          wb_dat_o,
	output reg                  wb_ack_o,
	// tester pins
	input  wire                 test_mode_pin,
	input  wire                 at_speed_test_mode_pin,
	input  wire                 capture_trigger_input,
	input  wire                 test_protect_in,
	// io clock edge marker
	input  wire                 io_sync_en,
	// outputs toward cluster headers
	output reg  [NUM_DOM-1:0]   core_clk_stop,
	output reg  [NUM_DOM-1:0]   io_clk_stop,
	output reg  [NUM_ML-1:0]    memlink_clk_stop,
	output reg                  misc_dbg_clk_stop,
	output reg                  array_wr_inhibit,
	output reg                  test_protect_out,
	output reg                  at_speed_fault_mode
);

	// byte-lane merge used by every writable register
	function [31:0] lane_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  sel;
		integer k;
		begin
			lane_merge = old_val;
			for (k = 0; k < 4; k = k + 1) begin
				if (sel[k]) begin
					lane_merge[k*8 +: 8] = new_val[k*8 +: 8];
				end
			end
		end
	endfunction

	// pulse window for one domain type: only targets that type can serve, only while it runs
	function [NUM_DOM-1:0] open_mask;
		input [NUM_DOM-1:0] tgt;
		input [NUM_DOM-1:0] capable;
		input               enable;
		begin
			open_mask = tgt & capable & {NUM_DOM{enable}};
		end
	endfunction

	// write strobe for one register, true in the cycle whose closing edge lands the write
	function wr_hit;
		input       wr;
		input [7:0] adr;
		input [7:0] reg_adr;
		begin
			wr_hit = wr & (adr == reg_adr);
		end
	endfunction

	// controller states; done keeps the stops closed until a new count is written,
	// so a stray second trigger cannot open the clocks with a stale count
	localparam [1:0] S_IDLE  = `TTCPC_S_IDLE;
	localparam [1:0] S_ALIGN = `TTCPC_S_ALIGN;
	localparam [1:0] S_RUN   = `TTCPC_S_RUN;
	localparam [1:0] S_DONE  = `TTCPC_S_DONE;

	// register state
	reg                 dsel_ff;
	reg [CNT_W-1:0]     count_ff;
	reg [NUM_DOM-1:0]   target_ff;
	reg [CNT_W-1:0]     rem_ff;
	reg [1:0]           state_ff;
	reg [1:0]           nxt_state;
	reg [CNT_W-1:0]     nxt_rem;

	// trigger synchroniser, first stage read only by the second
	reg                 trig_s1_ff;
	reg                 trig_s2_ff;
	reg                 trig_prev_ff;

	// first pipeline stage of the stop signals
	reg [NUM_DOM-1:0]   core_stage_ff;
	reg [NUM_DOM-1:0]   io_stage_ff;

	wire                mode_on;
	wire                bus_req;
	wire                bus_wr;
	wire                trig_rise;
	wire                running;
	wire [31:0]         ctrl_word;
	wire [31:0]         count_word;
	wire [31:0]         target_word;
	wire [31:0]         status_word;
	wire [31:0]         ctrl_new;
	wire [31:0]         count_new;
	wire [31:0]         target_new;
	wire [NUM_DOM-1:0]  core_pulse;
	wire [NUM_DOM-1:0]  io_pulse;
	reg  [31:0]         rd_mux;

	assign mode_on = test_mode_pin & at_speed_test_mode_pin;
	assign bus_req = wb_cyc_i & wb_stb_i;
	// write lands at the edge where ack is seen high by the master
	assign bus_wr  = bus_req & wb_we_i & wb_ack_o;

	assign ctrl_word   = {31'h00000000, dsel_ff};
	assign count_word  = {{(32-CNT_W){1'b0}}, count_ff};
	assign target_word = {{(32-NUM_DOM){1'b0}}, target_ff};
	assign status_word = {16'h0000, rem_ff, 3'h0, dsel_ff,
		(state_ff == S_DONE), (state_ff == S_RUN),
		(state_ff == S_ALIGN), mode_on};

	assign ctrl_new   = lane_merge(ctrl_word, wb_dat_i, wb_sel_i);
	assign count_new  = lane_merge(count_word, wb_dat_i, wb_sel_i);
	assign target_new = lane_merge(target_word, wb_dat_i, wb_sel_i);

	// read decode; unmapped addresses answer with zero
	always @* begin
		case (wb_adr_i)
			`TTCPC_ADR_CTRL:   rd_mux = ctrl_word;
			`TTCPC_ADR_COUNT:  rd_mux = count_word;
			`TTCPC_ADR_TARGET: rd_mux = target_word;
			`TTCPC_ADR_STATUS: rd_mux = status_word;
			default:           rd_mux = 32'h00000000;
		endcase
	end

	// one wait state: ack one cycle after the request, dropped the cycle after
	always @(posedge core_clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (bus_req & ~wb_ack_o & ~wb_we_i) begin
				wb_dat_o <= rd_mux;
			end
		end
	end

	// setup registers stand in for the scanned-in setup flops; each is reloaded
	// on its own address so a partial reload leaves the others untouched
	always @(posedge core_clk) begin
		if (srst) begin
			dsel_ff <= `TTCPC_DSEL_CORE;
		end else if (wr_hit(bus_wr, wb_adr_i, `TTCPC_ADR_CTRL)) begin
			dsel_ff <= ctrl_new[`TTCPC_CTRL_DSEL];
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			count_ff <= `TTCPC_RST_COUNT;
		end else if (wr_hit(bus_wr, wb_adr_i, `TTCPC_ADR_COUNT)) begin
			count_ff <= count_new[CNT_W-1:0];
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			target_ff <= `TTCPC_RST_TARGET;
		end else if (wr_hit(bus_wr, wb_adr_i, `TTCPC_ADR_TARGET)) begin
			target_ff <= target_new[NUM_DOM-1:0];
		end
	end

	// trigger pin is asynchronous; two flops before anything looks at it
	always @(posedge core_clk) begin
		if (srst) begin
			trig_s1_ff   <= 1'b0;
			trig_s2_ff   <= 1'b0;
			trig_prev_ff <= 1'b0;
		end else begin
			trig_s1_ff   <= capture_trigger_input;
			trig_s2_ff   <= trig_s1_ff;
			trig_prev_ff <= trig_s2_ff;
		end
	end

	assign trig_rise = trig_s2_ff & ~trig_prev_ff;

	// a zero count is refused so a tester slip cannot leave the clocks open
	always @* begin
		nxt_state = state_ff;
		nxt_rem   = rem_ff;
		case (state_ff)
			S_IDLE: begin
				if (mode_on & trig_rise & (count_ff != `TTCPC_ZERO_CNT)) begin
					nxt_state = S_ALIGN;
				end
			end
			S_ALIGN: begin
				if (io_sync_en) begin
					nxt_state = S_RUN;
					nxt_rem   = count_ff;
				end
			end
			S_RUN: begin
				nxt_rem = rem_ff - `TTCPC_ONE_CNT;
				if (rem_ff == `TTCPC_ONE_CNT) begin
					nxt_state = S_DONE;
				end
			end
			S_DONE: begin
				// stays parked until software writes a new count
				if (wr_hit(bus_wr, wb_adr_i, `TTCPC_ADR_COUNT)) begin
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		if (!mode_on) begin
			nxt_state = S_IDLE;
			nxt_rem   = `TTCPC_ZERO_CNT;
		end
	end

	always @(posedge core_clk) begin
		if (srst) begin
			state_ff <= S_IDLE;
			rem_ff   <= `TTCPC_ZERO_CNT;
		end else begin
			state_ff <= nxt_state;
			rem_ff   <= nxt_rem;
		end
	end

	assign running = (state_ff == S_RUN);

	// only one domain type is opened, chosen by the select bit
	assign core_pulse = open_mask(target_ff, `TTCPC_CORE_OK,
		running & (dsel_ff == `TTCPC_DSEL_CORE));
	assign io_pulse   = open_mask(target_ff, `TTCPC_IO_OK,
		running & (dsel_ff == `TTCPC_DSEL_IO));

	// first stage holds the open (run) pattern; zero at reset means all stopped
	always @(posedge core_clk) begin
		if (srst) begin
			core_stage_ff <= {NUM_DOM{1'b0}};
			io_stage_ff   <= {NUM_DOM{1'b0}};
		end else begin
			core_stage_ff <= core_pulse;
			// io stops only move on an io clock edge, so io pulse counts stay whole
			if (io_sync_en) begin
				io_stage_ff <= io_pulse;
			end
		end
	end

	// mode flags are registered so they leave the unit in step with the stops
	always @(posedge core_clk) begin
		if (srst) begin
			array_wr_inhibit    <= 1'b0;
			test_protect_out    <= 1'b0;
			at_speed_fault_mode <= 1'b0;
		end else begin
			at_speed_fault_mode <= mode_on;
			test_protect_out    <= test_protect_in | at_speed_test_mode_pin;
			array_wr_inhibit    <= mode_on;
		end
	end

	// core stops: inverse of the open pattern; outside the mode no stop is imposed
	always @(posedge core_clk) begin
		if (srst) begin
			core_clk_stop <= {NUM_DOM{1'b0}};
		end else if (!mode_on) begin
			core_clk_stop <= {NUM_DOM{1'b0}};
		end else begin
			core_clk_stop <= ~core_stage_ff;
		end
	end

	// in the mode io stops move only on an io clock edge and are held in between; leaving the mode clears them at once
	always @(posedge core_clk) begin
		if (srst) begin
			io_clk_stop <= {NUM_DOM{1'b0}};
		end else if (!mode_on) begin
			io_clk_stop <= {NUM_DOM{1'b0}};
		end else if (io_sync_en) begin
			io_clk_stop <= ~io_stage_ff;
		end
	end

	// memory-link is asynchronous to this clock, and the shared misc/debug stop
	// cannot give a clean single-domain capture, so both stay stopped in the mode
	always @(posedge core_clk) begin
		if (srst) begin
			memlink_clk_stop  <= {NUM_ML{1'b0}};
			misc_dbg_clk_stop <= 1'b0;
		end else begin
			memlink_clk_stop  <= {NUM_ML{mode_on}};
			misc_dbg_clk_stop <= mode_on;
		end
	end

endmodule // ttcpc_ctrl
`default_nettype wire

// ### tb/ttcpc_checker.sv
// assertions on the capture pulse controller ports
// assumes bind onto ttcpc_ctrl, one clock, srst synchronous active high
`timescale 1ns/1ps
`default_nettype none
module ttcpc_checker #(
	parameter CNT_W   = 8,
	parameter NUM_DOM = 24,
	parameter NUM_ML  = 4
) (
	input wire               core_clk,
	input wire               srst,
	input wire               wb_cyc_i,
	input wire               wb_stb_i,
	input wire               wb_ack_o,
	input wire               test_mode_pin,
	input wire               at_speed_test_mode_pin,
	input wire               test_protect_in,
	input wire               io_sync_en,
	input wire [NUM_DOM-1:0] core_clk_stop,
	input wire [NUM_DOM-1:0] io_clk_stop,
	input wire [NUM_ML-1:0]  memlink_clk_stop,
	input wire               misc_dbg_clk_stop,
	input wire               array_wr_inhibit,
	input wire               test_protect_out,
	input wire               at_speed_fault_mode
);
	// 9 bits so a stuck-low stop shows up before wrap
	reg  [8:0] run_ff;
	wire       md2;
	assign md2 = at_speed_fault_mode && test_mode_pin && at_speed_test_mode_pin;
	always @(posedge core_clk) begin
		if (srst || core_clk_stop[0] || !at_speed_fault_mode) run_ff <= 9'h000;
		else run_ff <= run_ff + 9'h001;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack timing wrong");
	property p_mode;
		!$past(srst) |-> at_speed_fault_mode == $past(test_mode_pin && at_speed_test_mode_pin);
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");
	property p_inh; $past(md2) && md2 |-> array_wr_inhibit; endproperty
	a_inh: assert property (p_inh) else $error("write inhibit low in mode");
	property p_prot;
		!$past(srst) |-> test_protect_out == $past(test_protect_in || at_speed_test_mode_pin);
	endproperty
	a_prot: assert property (p_prot) else $error("protect not ored");
	property p_ml; $past(md2) && md2 |-> &memlink_clk_stop; endproperty
	a_ml: assert property (p_ml) else $error("memlink stop released");
	property p_misc; $past(md2) && md2 |-> misc_dbg_clk_stop; endproperty
	a_misc: assert property (p_misc) else $error("shared stop released");
	property p_io; $past(md2) && md2 && !$stable(io_clk_stop) |-> $past(io_sync_en); endproperty
	a_io: assert property (p_io) else $error("io stop moved off io edge");
	property p_len; run_ff <= 9'h0ff; endproperty
	a_len: assert property (p_len) else $error("stop low too long");
	property p_mix;
		at_speed_fault_mode && |(~core_clk_stop & 24'h1fffff) |-> &(io_clk_stop | 24'h00ffff);
	endproperty
	a_mix: assert property (p_mix) else $error("core and io pulsed together");
	property p_align;
		at_speed_fault_mode && $past(&core_clk_stop) && !(&core_clk_stop) |-> $past(io_sync_en, 3);
	endproperty
	a_align: assert property (p_align) else $error("core window not io aligned");
	c_core: cover property ($fell(core_clk_stop[0]));
	c_io: cover property ($fell(io_clk_stop[16]));
	c_mode: cover property ($rose(at_speed_fault_mode));
endmodule // ttcpc_checker
bind ttcpc_ctrl ttcpc_checker #(.CNT_W(CNT_W), .NUM_DOM(NUM_DOM), .NUM_ML(NUM_ML)) u_chk (
	.core_clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .test_mode_pin,
	.at_speed_test_mode_pin, .test_protect_in, .io_sync_en, .core_clk_stop,
	.io_clk_stop, .memlink_clk_stop, .misc_dbg_clk_stop, .array_wr_inhibit,
	.test_protect_out, .at_speed_fault_mode
);
`default_nettype wire

// ### tb/ttcpc_ate.sv
// tester model: mode entry order, trigger, io edge marker
// assumes bench clock and synchronous reset
`timescale 1ns/1ps
`default_nettype none
module ttcpc_ate (
	input  wire  core_clk,
	input  wire  srst,
	input  wire  enter,
	input  wire  fire,
	output logic test_protect_in,
	output logic test_mode_pin,
	output logic at_speed_test_mode_pin,
	output logic capture_trigger_input,
	output logic io_sync_en
);
	logic [1:0] div_ff;
	always @(posedge core_clk) begin
		if (srst) begin
			div_ff <= 2'h0;
			io_sync_en <= 1'b0;
			test_protect_in <= 1'b0;
			test_mode_pin <= 1'b0;
			at_speed_test_mode_pin <= 1'b0;
			capture_trigger_input <= 1'b0;
		end else begin
			div_ff <= div_ff + 2'h1;
			// io clock is core/4, one marker per io edge
			io_sync_en <= (div_ff == 2'h2);
			test_protect_in <= enter;
			test_mode_pin <= enter & test_protect_in;
			at_speed_test_mode_pin <= enter & test_mode_pin;
			capture_trigger_input <= fire & at_speed_test_mode_pin;
		end
	end
endmodule // ttcpc_ate
`default_nettype wire

// ### tb/transition_test_capture_pulse_ctrl_test.sv
// bench: wishbone setup, tester model, counting capture pulses
// assumes ttcpc_ctrl, ttcpc_ate and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "ttcpc_defs.vh"
module transition_test_capture_pulse_ctrl_test;
	logic        core_clk = 1'b0;
	logic        srst = 1'b1;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic        enter = 1'b0;
	logic        fire = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	wire  [31:0] dat_o;
	wire  [23:0] cst, ist;
	wire  [3:0]  mls;
	wire         ack, tpi, tmp, asp, trg, iose, mds, inh, tpo, ifm;
	int          n_fail = 0, cmp_count = 0, lc, li;
	always #5 core_clk = ~core_clk;
	ttcpc_ctrl uut (.core_clk(core_clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .test_mode_pin(tmp), .at_speed_test_mode_pin(asp),
		.capture_trigger_input(trg), .test_protect_in(tpi), .io_sync_en(iose),
		.core_clk_stop(cst), .io_clk_stop(ist), .memlink_clk_stop(mls),
		.misc_dbg_clk_stop(mds), .array_wr_inhibit(inh), .test_protect_out(tpo),
		.at_speed_fault_mode(ifm));
	ttcpc_ate u_ate (.core_clk(core_clk), .srst(srst), .enter(enter), .fire(fire),
		.test_protect_in(tpi), .test_mode_pin(tmp), .at_speed_test_mode_pin(asp),
		.capture_trigger_input(trg), .io_sync_en(iose));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge core_clk);
		while (ack !== 1'b1) @(posedge core_clk);
		rdat = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge core_clk);
	endtask
	// count is written last: it is the reload that rearms the counter
	task automatic setup(input logic [31:0] ds, input logic [31:0] tg, input logic [31:0] n);
		wb(1'b1, `TTCPC_ADR_CTRL, ds);
		wb(1'b1, `TTCPC_ADR_TARGET, tg);
		wb(1'b1, `TTCPC_ADR_COUNT, n);
	endtask
	task automatic run(input int bc, input int bi);
		lc = 0;
		li = 0;
		@(posedge core_clk);
		fire <= 1'b1;
		repeat (300) begin
			@(posedge core_clk);
			fire <= 1'b0;
			if (cst[bc] === 1'b0) lc++;
			if (iose === 1'b1 && ist[bi] === 1'b0) li++;
		end
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		wb(1'b0, `TTCPC_ADR_TARGET, 32'h0);
		chk(rdat, {8'h00, `TTCPC_RST_TARGET});
		wb(1'b0, 8'h10, 32'h0);
		chk(rdat, 32'h0);
		wb(1'b1, `TTCPC_ADR_COUNT, 32'h1ff);
		wb(1'b0, `TTCPC_ADR_COUNT, 32'h0);
		chk(rdat, 32'h0ff);
		$display("test regs done");
		enter <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk({ifm, inh, tpo, mds, mls}, 32'hff);
		setup(32'h0, 32'h3, 32'h5);
		run(1, 16);
		chk(lc, 32'h5);
		chk(li, 32'h0);
		wb(1'b0, `TTCPC_ADR_STATUS, 32'h0);
		chk(rdat, 32'h9);
		run(1, 16);
		chk(lc, 32'h0);
		$display("test core done");
		setup(32'h1, 32'h10000, 32'h8);
		run(16, 16);
		chk(li, 32'h2);
		chk(lc, 32'h0);
		wb(1'b0, `TTCPC_ADR_CTRL, 32'h0);
		chk(rdat, 32'h1);
		wb(1'b0, `TTCPC_ADR_STATUS, 32'h0);
		chk(rdat, 32'h19);
		setup(32'h0, 32'h20000, 32'hff);
		run(17, 17);
		chk(lc, 32'hff);
		setup(32'h0, 32'h1, 32'h0);
		run(0, 16);
		chk(lc, 32'h0);
		$display("test capture done");
		enter <= 1'b0;
		repeat (8) @(posedge core_clk);
		chk({ifm, inh, tpo, cst}, 32'h0);
		$display("test exit done");
		final_report;
	end
endmodule // transition_test_capture_pulse_ctrl_test
`default_nettype wire
